// ==== rtl/relay_router_pkg.sv ====
// Shared constants for the indication and output-routing logic
// How it works
// RULE1 - Held start indication survives stage reset
// RULE2 - Starts self-clear, trips latch until button
// RULE3 - Trip lamp optionally lights on starts
// RULE4 - Blocking inputs and remote reset auto-clear
// RULE5 - Auto-reclose close command drives remote reset
// RULE6 - Latched indications never feed protection logic
// RULE7 - Eight relay drivers plus self-fault relay
// RULE8 - Each output drives its same-named relay
// RULE9 - Any stage signal routes anywhere
// RULE10 - Only heavy outputs get breaker duty
// RULE11 - Control inputs block, reset or select bank
// RULE12 - Breaker sense high means breaker open
// RULE13 - Permanent fault lights lamp, shows code
// RULE14 - Supply deviation flag raises self-fault alarm
// RULE15 - Power-up clears latches; inputs synchronised
// RULE16 - Per-source enables, outputs OR their sources
package relay_router_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int N_STAGE = 8;
  localparam int N_SRC   = 2 * N_STAGE;
  localparam int N_OUT   = 8;
  localparam int N_MOD   = 3;
  localparam int CODE_W  = 8;
  localparam int N_SUP   = 4;
  localparam int N_PIN   = 7;

  // ----------------------------------------
  // Relay output positions
  // ----------------------------------------
  localparam int OUT_SIG1  = 0;
  localparam int OUT_SIG2  = 1;
  localparam int OUT_SIG3  = 2;
  localparam int OUT_SIG4  = 3;
  localparam int OUT_HVY1  = 4;
  localparam int OUT_HVY2  = 5;
  localparam int OUT_HVY3  = 6;
  localparam int OUT_CLOSE = 7;

  // ----------------------------------------
  // Synchronised pin positions
  // ----------------------------------------
  localparam int PIN_BLK1  = 0;
  localparam int PIN_BLK2  = 1;
  localparam int PIN_REMOTE_INDICATOR_RESET  = 2;
  localparam int PIN_BREAKER_OPEN_SENSE = 3;
  localparam int PIN_ARINH = 4;
  localparam int PIN_ARCTL = 5;
  localparam int PIN_RBTN  = 6;

  // Auto-reset enable positions
  localparam int ARST_BLK1 = 0;
  localparam int ARST_BLK2 = 1;
  localparam int ARST_REMOTE_INDICATOR_RESET = 2;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [N_OUT-1:0]   RST_RELAY = 8'h00;
  localparam logic [N_STAGE-1:0] RST_IND   = 8'h00;
  localparam int SYNC_STAGES = 2;

endpackage : relay_router_pkg

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for asynchronous control pins
`timescale 1ns/10ps
module pin_sync
  import relay_router_pkg::*;
#(
  parameter int W = N_PIN
)
(
  input  wire logic         i_clk,   // System clock
  input  wire logic         i_srst,  // Sync reset
  input  wire logic         i_ce,    // Clock enable
  input  wire logic [W-1:0] i_pin,   // Raw pins
  output logic      [W-1:0] o_sync   // Synchronised levels
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (i_ce)
    begin
      st_d.meta = i_pin;
      st_d.sync = st_q.meta;  // RULE15
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_sync = st_q.sync;

endmodule : pin_sync

// ==== rtl/stage_indicators.sv ====
// Per-stage start and trip indication latches
`timescale 1ns/10ps
module stage_indicators
  import relay_router_pkg::*;
(
  input  wire logic               i_clk,        // System clock
  input  wire logic               i_srst,       // Sync reset
  input  wire logic               i_ce,         // Clock enable
  input  wire logic [N_STAGE-1:0] i_start,      // Live stage starts
  input  wire logic [N_STAGE-1:0] i_trip,       // Live stage trips
  input  wire logic               i_start_hold, // Keep start lit
  input  wire logic               i_clear,      // Indication reset
  output logic      [N_STAGE-1:0] o_start_ind,  // Start indications
  output logic      [N_STAGE-1:0] o_trip_ind    // Trip indications
);

  typedef struct packed {
    logic [N_STAGE-1:0] start_ind;
    logic [N_STAGE-1:0] trip_ind;
  } ind_state_t;

  ind_state_t st_q;
  ind_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (i_ce)
    begin
      // A new event wins over a clear in the same cycle
      if (i_start_hold)
        st_d.start_ind = i_start | (st_q.start_ind & ~{N_STAGE{i_clear}}); // RULE1
      else
        st_d.start_ind = i_start;                                           // RULE2
      st_d.trip_ind = i_trip | (st_q.trip_ind & ~{N_STAGE{i_clear}});      // RULE2
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_q.start_ind <= RST_IND;  // RULE15
      st_q.trip_ind  <= RST_IND;
    end
    else
      st_q <= st_d;
  end

  assign o_start_ind = st_q.start_ind;
  assign o_trip_ind  = st_q.trip_ind;

endmodule : stage_indicators

// ==== rtl/relay_indicator_output_router.sv ====
// Top: stage signal routing, indications, control inputs, self-supervision
`timescale 1ns/10ps
module relay_indicator_output_router
  import relay_router_pkg::*;
(
  input  wire logic                     i_clk,                    // 200 MHz clock
  input  wire logic                     i_srst,                   // Sync reset, high
  input  wire logic                     i_ce,                     // Clock enable
  // Protection stages
  input  wire logic [N_STAGE-1:0]       i_stage_start,            // Live starts
  input  wire logic [N_STAGE-1:0]       i_stage_trip,             // Live trips
  input  wire logic                     i_ar_close_cmd,           // AR close command
  // Pins
  input  wire logic                     i_blocking_input_one,     // Control pin 1
  input  wire logic                     i_blocking_input_two,     // Control pin 2
  input  wire logic                     i_remote_indicator_reset, // Remote reset pin
  input  wire logic                     i_breaker_open_sense,     // High: CB open
  input  wire logic                     i_ar_inhibit,             // AR inhibit pin
  input  wire logic                     i_ar_control,             // AR control pin
  input  wire logic                     i_reset_button,           // Front reset button
  // Configuration
  input  wire logic [N_OUT*N_SRC-1:0]   i_route_en,               // Source enables/output
  input  wire logic [N_SRC-1:0]         i_ar_init_en,             // AR initiation sources
  input  wire logic [N_OUT-1:0]         i_latch_en,               // Latching outputs
  input  wire logic                     i_start_hold,             // Hold start indications
  input  wire logic                     i_lamp_on_start,          // Lamp also on starts
  input  wire logic [2:0]               i_auto_reset_en,          // Auto reset sources
  input  wire logic [N_STAGE-1:0]       i_block_one_sel,          // Stages blocked by pin 1
  input  wire logic [N_STAGE-1:0]       i_block_two_sel,          // Stages blocked by pin 2
  input  wire logic [1:0]               i_bank_sel,               // Pins selecting bank 2
  // Self-supervision
  input  wire logic [N_MOD-1:0]         i_perm_fault,             // Module permanent fault
  input  wire logic [N_MOD*CODE_W-1:0]  i_fault_code,             // Module fault codes
  input  wire logic [N_SUP-1:0]         i_supply_dev,             // Supply out of margin
  // Relay outputs
  output logic                          o_signal_output_one,      // Signal relay 1
  output logic                          o_signal_output_two,      // Signal relay 2
  output logic                          o_signal_output_three,    // Signal relay 3
  output logic                          o_signal_output_four,     // Signal relay 4
  output logic                          o_heavy_trip_output_one,  // Heavy relay 1
  output logic                          o_heavy_trip_output_two,  // Heavy relay 2
  output logic                          o_heavy_trip_output_three,// Heavy relay 3
  output logic                          o_breaker_close_output,   // Close relay
  output logic                          o_self_fault_output,      // Self-fault relay
  // Status
  output logic                          o_ar_initiate,            // AR initiation
  output logic                          o_ar_inhibit,             // Synced AR inhibit
  output logic                          o_ar_control,             // Synced AR control
  output logic [N_STAGE-1:0]            o_stage_block,            // Stage blocking
  output logic                          o_second_bank,            // Second settings
  output logic                          o_breaker_open,           // Breaker open
  output logic [N_STAGE-1:0]            o_start_ind,              // Start indications
  output logic [N_STAGE-1:0]            o_trip_ind,               // Trip indications
  output logic                          o_trip_lamp,              // Front trip lamp
  output logic [N_MOD-1:0]              o_fault_lamp,             // Module fault lamps
  output logic [N_MOD*CODE_W-1:0]       o_fault_display           // Module fault codes
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic route_or(input logic [N_SRC-1:0] src,
                                    input logic [N_SRC-1:0] en);
    route_or = |(src & en);
  endfunction : route_or

  typedef struct packed {
    logic [N_OUT-1:0]        relay;
    logic [N_OUT-1:0]        latched;
    logic                    ar_init;
    logic                    bank2;
    logic                    cb_open;
    logic [N_STAGE-1:0]      block;
    logic                    lamp;
    logic [N_MOD-1:0]        flamp;
    logic [N_MOD*CODE_W-1:0] fcode;
    logic                    self_fault;
  } main_state_t;

  main_state_t st_q;
  main_state_t st_d;

  logic [N_PIN-1:0]   pin_raw;
  logic [N_PIN-1:0]   pin_s;
  logic               remote_indicator_reset_eff;
  logic               ind_clear;
  logic [N_STAGE-1:0] blk_now;
  logic [N_STAGE-1:0] start_g;
  logic [N_STAGE-1:0] trip_g;
  logic [N_SRC-1:0]   src;
  logic [N_OUT-1:0]   live;
  logic [N_STAGE-1:0] start_ind;
  logic [N_STAGE-1:0] trip_ind;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  assign pin_raw[PIN_BLK1]  = i_blocking_input_one;
  assign pin_raw[PIN_BLK2]  = i_blocking_input_two;
  assign pin_raw[PIN_REMOTE_INDICATOR_RESET]  = i_remote_indicator_reset;
  assign pin_raw[PIN_BREAKER_OPEN_SENSE] = i_breaker_open_sense;
  assign pin_raw[PIN_ARINH] = i_ar_inhibit;
  assign pin_raw[PIN_ARCTL] = i_ar_control;
  assign pin_raw[PIN_RBTN]  = i_reset_button;

  pin_sync #(.W(N_PIN)) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_ce   (i_ce),
    .i_pin  (pin_raw),
    .o_sync (pin_s)
  );

  // ----------------------------------------
  // Control input functions
  // ----------------------------------------
  assign remote_indicator_reset_eff  = pin_s[PIN_REMOTE_INDICATOR_RESET] | i_ar_close_cmd;                         // RULE5
  assign ind_clear = pin_s[PIN_RBTN]                                           // RULE2
                   | (i_auto_reset_en[ARST_BLK1] & pin_s[PIN_BLK1])            // RULE4
                   | (i_auto_reset_en[ARST_BLK2] & pin_s[PIN_BLK2])            // RULE4
                   | (i_auto_reset_en[ARST_REMOTE_INDICATOR_RESET] & remote_indicator_reset_eff);                  // RULE4

  assign blk_now = ({N_STAGE{pin_s[PIN_BLK1]}} & i_block_one_sel)              // RULE11
                 | ({N_STAGE{pin_s[PIN_BLK2]}} & i_block_two_sel);

  // Routing sees only live, unblocked stage signals, never indications
  assign start_g = i_stage_start & ~blk_now;                                   // RULE6
  assign trip_g  = i_stage_trip & ~blk_now;
  assign src     = {trip_g, start_g};

  // ----------------------------------------
  // Routing matrix
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++)
    begin : g_route
      assign live[g] = route_or(src, i_route_en[g*N_SRC +: N_SRC]);            // RULE9 RULE16
    end
  endgenerate

  // ----------------------------------------
  // Indications
  // ----------------------------------------
  stage_indicators u_ind (
    .i_clk        (i_clk),
    .i_srst       (i_srst),
    .i_ce         (i_ce),
    .i_start      (start_g),
    .i_trip       (trip_g),
    .i_start_hold (i_start_hold),
    .i_clear      (ind_clear),
    .o_start_ind  (start_ind),
    .o_trip_ind   (trip_ind)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (i_ce)
    begin
      // Set wins over clear so a trip arriving with a reset is kept
      st_d.latched    = (live & i_latch_en) | (st_q.latched & ~{N_OUT{ind_clear}}); // RULE11
      st_d.relay      = live | (st_q.latched & i_latch_en);                         // RULE8
      st_d.ar_init    = route_or(src, i_ar_init_en);                                // RULE9
      st_d.bank2      = (i_bank_sel[0] & pin_s[PIN_BLK1])
                      | (i_bank_sel[1] & pin_s[PIN_BLK2]);                          // RULE11
      st_d.cb_open    = pin_s[PIN_BREAKER_OPEN_SENSE];                                           // RULE12
      st_d.block      = blk_now;
      st_d.lamp       = (|trip_ind) | (i_lamp_on_start & (|start_ind));             // RULE3
      st_d.flamp      = i_perm_fault;                                               // RULE13
      for (int m = 0; m < N_MOD; m++)
      begin
        st_d.fcode[m*CODE_W +: CODE_W] = i_perm_fault[m] ?
                                         i_fault_code[m*CODE_W +: CODE_W] : '0;     // RULE13
      end
      st_d.self_fault = (|i_supply_dev) | (|i_perm_fault);                          // RULE14
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_q         <= '0;                                                           // RULE15
      st_q.relay   <= RST_RELAY;
      st_q.latched <= RST_RELAY;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Breaker duty belongs on the heavy and close relays only
  assign o_signal_output_one       = st_q.relay[OUT_SIG1];                        // RULE7
  assign o_signal_output_two       = st_q.relay[OUT_SIG2];
  assign o_signal_output_three     = st_q.relay[OUT_SIG3];
  assign o_signal_output_four      = st_q.relay[OUT_SIG4];
  assign o_heavy_trip_output_one   = st_q.relay[OUT_HVY1];                        // RULE10
  assign o_heavy_trip_output_two   = st_q.relay[OUT_HVY2];
  assign o_heavy_trip_output_three = st_q.relay[OUT_HVY3];
  assign o_breaker_close_output    = st_q.relay[OUT_CLOSE];
  assign o_self_fault_output       = st_q.self_fault;                             // RULE7
  assign o_ar_initiate             = st_q.ar_init;
  assign o_ar_inhibit              = pin_s[PIN_ARINH];
  assign o_ar_control              = pin_s[PIN_ARCTL];
  assign o_stage_block             = st_q.block;
  assign o_second_bank             = st_q.bank2;
  assign o_breaker_open            = st_q.cb_open;
  assign o_start_ind               = start_ind;
  assign o_trip_ind                = trip_ind;
  assign o_trip_lamp               = st_q.lamp;
  assign o_fault_lamp              = st_q.flamp;
  assign o_fault_display           = st_q.fcode;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_route_or_sources: assert property ( // RULE16
    i_ce |=> (o_heavy_trip_output_one == ($past(live[OUT_HVY1]) |
              ($past(st_q.latched[OUT_HVY1]) & $past(i_latch_en[OUT_HVY1])))))
    else $error("heavy relay one not OR of its sources");

  a_routed_trip_fires: assert property ( // RULE9
    (i_ce && |(i_stage_trip & ~blk_now & i_route_en[OUT_SIG1*N_SRC+N_STAGE +: N_STAGE]))
    |=> o_signal_output_one)
    else $error("routed trip did not reach signal relay one");

  a_trip_ind_holds: assert property ( // RULE2
    (i_ce && trip_ind[0] && !ind_clear && !i_stage_trip[0]) |=> trip_ind[0])
    else $error("trip indication dropped without reset");

  a_start_auto_clear: assert property ( // RULE2
    (i_ce && !i_start_hold && !i_stage_start[0]) |=> !start_ind[0])
    else $error("start indication stayed lit without hold");

  a_start_held: assert property ( // RULE1
    (i_ce && i_start_hold && start_ind[0] && !ind_clear) |=> start_ind[0])
    else $error("held start indication cleared");

  a_lamp_on_start: assert property ( // RULE3
    (i_ce && i_lamp_on_start && |start_ind) |=> o_trip_lamp)
    else $error("trip lamp not lit on start");

  a_auto_reset_clears: assert property ( // RULE4
    (i_ce && i_auto_reset_en[ARST_BLK1] && pin_s[PIN_BLK1] && !i_stage_trip[0]) |=> !trip_ind[0])
    else $error("blocking input did not auto-clear trip indication");

  a_close_resets: assert property ( // RULE5
    (i_ce && i_auto_reset_en[ARST_REMOTE_INDICATOR_RESET] && i_ar_close_cmd && !i_stage_trip[0]) |=> !trip_ind[0])
    else $error("reclose command did not reset indication");

  a_breaker_sense: assert property ( // RULE12
    (i_ce [*3]) |=> (o_breaker_open == $past(i_breaker_open_sense, 3)))
    else $error("breaker open status wrong");

  a_fault_lamp_code: assert property ( // RULE13
    (i_ce && i_perm_fault[0]) |=> (o_fault_lamp[0] &&
      o_fault_display[CODE_W-1:0] == $past(i_fault_code[CODE_W-1:0])))
    else $error("fault lamp or code missing");

  a_supply_alarm: assert property ( // RULE14
    (i_ce && |i_supply_dev) |=> o_self_fault_output)
    else $error("supply deviation gave no alarm");

  a_block_gates: assert property ( // RULE11
    (i_ce && pin_s[PIN_BLK1] && i_block_one_sel[0] && i_stage_trip[0])
    |=> !trip_ind[0] || $past(trip_ind[0]))
    else $error("blocked stage still indicated trip");

  a_bank_select: assert property ( // RULE11
    (i_ce && i_bank_sel[0] && pin_s[PIN_BLK1]) |=> o_second_bank)
    else $error("blocking input one did not select second bank");

  a_close_relay_map: assert property ( // RULE8
    (i_ce && live[OUT_CLOSE]) |=> o_breaker_close_output)
    else $error("close relay did not follow its routed sources");

  // Clock enable low must hold every register of this level
  a_ce_freezes: assert property ( // RULE15
    !i_ce |=> $stable(st_q) && $stable(start_ind) && $stable(trip_ind))
    else $error("state moved while clock enable low");

  // Reset is checked with the default disable switched off
  a_reset_clears: assert property ( // RULE15
    disable iff (1'b0) i_srst |=> (st_q == '0) && (start_ind == '0) && (trip_ind == '0))
    else $error("reset left indications or relays set");

  c_trip_latched:   cover property (i_ce && trip_g[0] ##1 trip_ind[0] ##[1:5] ind_clear);
  c_reclose_reset:  cover property (i_ce && i_ar_close_cmd && |trip_ind);
  c_second_bank:    cover property (o_second_bank);
  c_self_fault:     cover property (o_self_fault_output);
  c_ce_frozen:      cover property (!i_ce ##1 i_ce);

endmodule : relay_indicator_output_router

// ==== testbench/stage_model.sv ====
// Behavioural protection stages and auto-reclose close command
`timescale 1ns/10ps
module stage_model
  import relay_router_pkg::*;
(
  input  wire logic               i_clk,     // System clock
  input  wire logic               i_srst,    // Sync reset
  input  wire logic [N_STAGE-1:0] i_fault,   // Fault present per stage
  input  wire logic               i_reclose, // Close request
  output logic      [N_STAGE-1:0] o_start,   // Stage starts
  output logic      [N_STAGE-1:0] o_trip,    // Stage trips
  output logic                    o_close    // AR close command
);
  // ----------------------------------------
  // Start one cycle after fault, trip if still faulted a cycle later
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_start <= 8'h00;
      o_trip  <= 8'h00;
      o_close <= 1'b0;
    end
    else
    begin
      o_start <= i_fault;
      o_trip  <= i_fault & o_start;
      o_close <= i_reclose;
    end
  end
endmodule : stage_model

// ==== testbench/test_relay_indicator_output_router.sv ====
// Self-checking bench for the indication and output-routing block
`timescale 1ns/10ps
module test_relay_indicator_output_router
  import relay_router_pkg::*;
;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         ce = 1'b1;
  logic [7:0]   fault = 8'h00;
  logic         reclose = 1'b0;
  logic [3:0]   clr = 4'h0;
  logic         cb_open = 1'b0;
  logic         ar_pin = 1'b0;
  logic [127:0] route_en = 128'h0;
  logic [15:0]  ar_init_en = 16'h0;
  logic [7:0]   latch_en = 8'h00;
  logic         hold = 1'b0;
  logic         lamp_start = 1'b0;
  logic [2:0]   auto_en = 3'h0;
  logic [7:0]   blk_sel = 8'h00;
  logic [1:0]   bank_sel = 2'h0;
  logic [2:0]   perm = 3'h0;
  logic [23:0]  code = 24'h33a511;
  logic [3:0]   sup = 4'h0;
  logic [7:0]   st_start, st_trip, relays, blk, s_ind, t_ind;
  logic         close, self_f, ar_ini, ar_inh, ar_ctl, bank2, cb_o, lamp;
  logic [2:0]   f_lamp;
  logic [23:0]  f_disp;
  int           n_errors = 0;
  int           n_compared = 0;

  always #2.5 clk = ~clk;

  stage_model u_stage_model (.i_clk(clk), .i_srst(srst), .i_fault(fault),
    .i_reclose(reclose), .o_start(st_start), .o_trip(st_trip), .o_close(close));

  relay_indicator_output_router u_relay_indicator_output_router (
    .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_stage_start(st_start),
    .i_stage_trip(st_trip), .i_ar_close_cmd(close), .i_blocking_input_one(clr[0]),
    .i_blocking_input_two(clr[1]), .i_remote_indicator_reset(clr[2]),
    .i_breaker_open_sense(cb_open), .i_ar_inhibit(ar_pin), .i_ar_control(ar_pin),
    .i_reset_button(clr[3]), .i_route_en(route_en), .i_ar_init_en(ar_init_en),
    .i_latch_en(latch_en), .i_start_hold(hold), .i_lamp_on_start(lamp_start),
    .i_auto_reset_en(auto_en), .i_block_one_sel(blk_sel), .i_block_two_sel(blk_sel),
    .i_bank_sel(bank_sel), .i_perm_fault(perm), .i_fault_code(code),
    .i_supply_dev(sup), .o_signal_output_one(relays[0]), .o_signal_output_two(relays[1]),
    .o_signal_output_three(relays[2]), .o_signal_output_four(relays[3]),
    .o_heavy_trip_output_one(relays[4]), .o_heavy_trip_output_two(relays[5]),
    .o_heavy_trip_output_three(relays[6]), .o_breaker_close_output(relays[7]),
    .o_self_fault_output(self_f), .o_ar_initiate(ar_ini), .o_ar_inhibit(ar_inh),
    .o_ar_control(ar_ctl), .o_stage_block(blk), .o_second_bank(bank2),
    .o_breaker_open(cb_o), .o_start_ind(s_ind), .o_trip_ind(t_ind),
    .o_trip_lamp(lamp), .o_fault_lamp(f_lamp), .o_fault_display(f_disp));

  // ----------------------------------------
  // Helpers: checks land 1 ns after the edge so updates have settled
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    cyc(3);
    chk("relays after reset", relays, 8'h00);
    chk("trip ind after reset", t_ind, 8'h00);
    // Stage k trip to relay k; only relays 4 to 7 would carry breaker duty
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      route_en <= 128'h1 << (k * 16 + 8 + k);
      ar_init_en <= 16'h0100 << k;
      fault <= 8'h01 << k;
      cyc(3);
      chk("routed relay", relays, 8'h01 << k);
      chk("ar initiate", ar_ini, 1'b1);
      @(posedge clk);
      fault <= 8'h00;
      cyc(3);
      chk("relay released", relays, 8'h00);
    end
    chk("trips latched", t_ind, 8'hff);
    chk("lamp on trip", lamp, 1'b1);
    chk("starts cleared", s_ind, 8'h00);
    @(posedge clk);
    clr <= 4'h8;
    cyc(3);
    chk("button clears trips", t_ind, 8'h00);
    cyc(1);
    chk("lamp off", lamp, 1'b0);
    // Held start and lamp on start, with trip indication clear
    @(posedge clk);
    clr <= 4'h0;
    hold <= 1'b1;
    lamp_start <= 1'b1;
    route_en <= 128'h1;
    fault <= 8'h01;
    @(posedge clk);
    fault <= 8'h00;
    cyc(4);
    chk("start held", s_ind, 8'h01);
    chk("lamp on start", lamp, 1'b1);
    chk("unlatched relay follows stage", relays, 8'h00);
    chk("no trip", t_ind, 8'h00);
    @(posedge clk);
    lamp_start <= 1'b0;
    latch_en <= 8'h01;
    cyc(2);
    chk("lamp starts disabled", lamp, 1'b0);
    // Latched relay: cleared by each auto-reset source, kept by blocking input one while it is not enabled
    for (int j = 0; j < 5; j++)
    begin
      @(posedge clk);
      auto_en <= (j == 0) ? 3'h6 : 3'h7;
      fault <= 8'h01;
      repeat (2) @(posedge clk);
      fault <= 8'h00;
      cyc(2);
      chk("relay latched", relays, 8'h01);
      chk("trip latched", t_ind, 8'h01);
      @(posedge clk);
      clr <= (j == 0) ? 4'h1 : (j == 4) ? 4'h0 : 4'h1 << (j - 1);
      reclose <= (j == 4);
      cyc(4);
      chk("auto reset", relays, (j == 0) ? 8'h01 : 8'h00);
      chk("held start reset", s_ind, (j == 0) ? 8'h01 : 8'h00);
      chk("trip ind reset", t_ind, (j == 0) ? 8'h01 : 8'h00);
      @(posedge clk);
      clr <= 4'h0;
      reclose <= 1'b0;
      cyc(3);
    end
    // Control pin blocks stage and selects second bank
    @(posedge clk);
    auto_en <= 3'h0;
    bank_sel <= 2'h1;
    blk_sel <= 8'h01;
    clr <= 4'h1;
    cyc(3);
    chk("stage blocked", blk, 8'h01);
    chk("second bank", bank2, 1'b1);
    @(posedge clk);
    fault <= 8'h01;
    cyc(3);
    chk("blocked start ignored", s_ind, 8'h00);
    chk("blocked relay off", relays, 8'h00);
    @(posedge clk);
    fault <= 8'h00;
    clr <= 4'h0;
    cb_open <= 1'b1;
    ar_pin <= 1'b1;
    cyc(3);
    chk("breaker open", cb_o, 1'b1);
    chk("ar pins synced", {ar_inh, ar_ctl}, 2'h3);
    chk("bank released", bank2, 1'b0);
    @(posedge clk);
    cb_open <= 1'b0;
    perm <= 3'h2;
    cyc(1);
    chk("fault lamp", f_lamp, 3'h2);
    chk("fault code", f_disp, 24'h00a500);
    @(posedge clk);
    perm <= 3'h0;
    sup <= 4'h4;
    cyc(1);
    chk("supply alarm", self_f, 1'b1);
    chk("code cleared", f_disp, 24'h000000);
    chk("breaker closed", cb_o, 1'b0);
    @(posedge clk);
    sup <= 4'h0;
    cyc(1);
    chk("alarm cleared", self_f, 1'b0);
    // Clock enable low freezes every register
    @(posedge clk);
    ce <= 1'b0;
    perm <= 3'h1;
    cyc(2);
    chk("frozen lamp", f_lamp, 3'h0);
    @(posedge clk);
    ce <= 1'b1;
    cyc(1);
    chk("thawed lamp", f_lamp, 3'h1);
    complete_run();
  end
endmodule : test_relay_indicator_output_router
